// *** core/abx_exec.sv ***
// Decode and execute of register AND, literal AND, bit clear and bit set.
//----------------------------------------------------------------------
// Summary of operation
//----------------------------------------------------------------------
// Summary of operation
// - Upper six bits 000101 AND work with file.
// - Destination bit picks work or file.
// - Register AND updates zero flag only.
// - Upper nibble 1110 ANDs literal into work.
// - Upper nibble 0100 clears selected file bit.
// - Upper nibble 0101 sets selected file bit.
`timescale 1ns/1ps
`include "abx_consts.svh"
module abx_exec
(
   // Clock and reset.
   input wire logic i_clk,
   input wire logic i_rst_n,
   // Instruction from fetch, valid for one cycle each.
   input wire logic i_insn_vld,
   input wire logic [11:0] i_insn,
   // Current operand values on the same clock.
   input wire logic [7:0] i_work,
   input wire logic [7:0] i_file_rd,
   // Read address to the file register array.
   output logic [4:0] o_file_raddr,
   // Registered write-back to work, file and zero flag.
   output logic o_work_we,
   output logic [7:0] o_work_wd,
   output logic o_file_we,
   output logic [4:0] o_file_waddr,
   output logic [7:0] o_file_wd,
   output logic o_zero_we,
   output logic o_zero_val
);
   //----------------------------------------------------------------------
   // Decode
   //----------------------------------------------------------------------
   abx_pkg::abx_op_type op; // Decoded operation.
   logic [2:0] bit_sel; // Selected bit number.
   logic [7:0] bit_mask; // One-hot mask of the selected bit.
   abx_pkg::abx_wb_type nxt_wb_ff; // Next write-back bundle.
   abx_pkg::abx_wb_type wb_ff; // Registered write-back bundle.

   // The file address is the low five bits for every handled form.
   // It is the only output that is not registered, so the operand that it reads
   // arrives in the same cycle as the word that names it.
   assign o_file_raddr = i_insn[`ABX_ADDR_W-1:0];
   assign bit_sel = i_insn[`ABX_BIT_HI:`ABX_BIT_LO];

   // Classify the word; anything else is no operation here.
   always_comb
   begin
      op = abx_pkg::ABX_OP_NONE;
      bit_mask = 8'h01 << bit_sel;
      // An empty slot decodes to no operation whatever the word holds.
      if (!i_insn_vld)
      begin
         op = abx_pkg::ABX_OP_NONE;
      end
      // The six-bit register AND pattern goes first; no four-bit pattern overlaps it.
      else if (i_insn[`ABX_OP6_HI:`ABX_OP6_LO] == `ABX_OP_AND_FILE)
      begin
         op = abx_pkg::ABX_OP_ANDF;
      end
      // Literal AND into the working register.
      else if (i_insn[`ABX_OP4_HI:`ABX_OP4_LO] == `ABX_OP_AND_LIT)
      begin
         op = abx_pkg::ABX_OP_ANDK;
      end
      // Clear of one bit of a file register.
      else if (i_insn[`ABX_OP4_HI:`ABX_OP4_LO] == `ABX_OP_BCLR)
      begin
         op = abx_pkg::ABX_OP_BCLR;
      end
      // Set of one bit of a file register.
      else if (i_insn[`ABX_OP4_HI:`ABX_OP4_LO] == `ABX_OP_BSET)
      begin
         op = abx_pkg::ABX_OP_BSET;
      end
   end

   //----------------------------------------------------------------------
   // Execute
   //----------------------------------------------------------------------
   // Compute the result and write enables in the same cycle as decode.
   always_comb
   begin
      nxt_wb_ff = '0;
      nxt_wb_ff.f_addr = i_insn[`ABX_ADDR_W-1:0];
      case (op)
         // Register AND; the destination bit picks one target and the zero flag follows.
         abx_pkg::ABX_OP_ANDF:
         begin
            nxt_wb_ff.data = i_work & i_file_rd;
            nxt_wb_ff.f_we = i_insn[`ABX_DEST_BIT];
            nxt_wb_ff.w_we = ~i_insn[`ABX_DEST_BIT];
            nxt_wb_ff.z_we = 1'b1;
            nxt_wb_ff.z_val = ((i_work & i_file_rd) == 8'h00);
         end
         // Literal AND; the result always goes to the working register.
         abx_pkg::ABX_OP_ANDK:
         begin
            nxt_wb_ff.data = i_work & i_insn[`ABX_DATA_W-1:0];
            nxt_wb_ff.w_we = 1'b1;
            nxt_wb_ff.z_we = 1'b1;
            nxt_wb_ff.z_val = ((i_work & i_insn[`ABX_DATA_W-1:0]) == 8'h00);
         end
         // Bit clear; the other bits are written back as read and no flag moves.
         abx_pkg::ABX_OP_BCLR:
         begin
            nxt_wb_ff.data = i_file_rd & ~bit_mask;
            nxt_wb_ff.f_we = 1'b1;
         end
         // Bit set; the other bits are written back as read and no flag moves.
         abx_pkg::ABX_OP_BSET:
         begin
            nxt_wb_ff.data = i_file_rd | bit_mask;
            nxt_wb_ff.f_we = 1'b1;
         end
         // No operation; all write enables stay low.
         default:
         begin
            nxt_wb_ff.data = `ABX_RESULT_RST;
         end
      endcase
   end

   //----------------------------------------------------------------------
   // Write-back register
   //----------------------------------------------------------------------
   // There is no forwarding: a result lands one cycle after its word, so a word
   // that needs it must be given the updated operand by the caller.
   // Register the write-back; one word retires per cycle with no stall.
   always_ff @(posedge i_clk)
   begin
      if (!i_rst_n)
      begin
         wb_ff <= '0;
      end
      else
      begin
         wb_ff <= nxt_wb_ff;
      end
   end

   //----------------------------------------------------------------------
   // Outputs
   //----------------------------------------------------------------------
   // Outputs come straight from the write-back register.
   assign o_work_we = wb_ff.w_we;
   assign o_work_wd = wb_ff.data;
   assign o_file_we = wb_ff.f_we;
   assign o_file_waddr = wb_ff.f_addr;
   assign o_file_wd = wb_ff.data;
   assign o_zero_we = wb_ff.z_we;
   assign o_zero_val = wb_ff.z_val;

   //----------------------------------------------------------------------
   // Checks
   //----------------------------------------------------------------------
   // All checks run on the core clock and rest while reset is held.
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_rst_n);

   // Raw opcode matches, worked out from the word apart from the decoder above.
   logic chk_and_file; // Valid register AND word.
   logic chk_and_lit; // Valid literal AND word.
   logic chk_bit_clr; // Valid bit clear word.
   logic chk_bit_set; // Valid bit set word.
   assign chk_and_file = i_insn_vld && (i_insn[`ABX_OP6_HI:`ABX_OP6_LO] == `ABX_OP_AND_FILE);
   assign chk_and_lit = i_insn_vld && (i_insn[`ABX_OP4_HI:`ABX_OP4_LO] == `ABX_OP_AND_LIT);
   assign chk_bit_clr = i_insn_vld && (i_insn[`ABX_OP4_HI:`ABX_OP4_LO] == `ABX_OP_BCLR);
   assign chk_bit_set = i_insn_vld && (i_insn[`ABX_OP4_HI:`ABX_OP4_LO] == `ABX_OP_BSET);

   // Register AND: the result is the AND of the operands given with the word.
   andf_result_a: assert property (chk_and_file |=>
      o_work_wd == ($past(i_work) & $past(i_file_rd))) else $error("and result wrong");
   // Register AND: the destination bit steers the write to exactly one target.
   andf_dest_a: assert property (chk_and_file |=>
      o_file_we == $past(i_insn[`ABX_DEST_BIT]) && o_work_we != $past(i_insn[`ABX_DEST_BIT]))
      else $error("and destination wrong");
   // Register AND: the zero flag is written and tracks the 8-bit result.
   andf_zero_a: assert property (chk_and_file |=>
      o_zero_we && o_zero_val == (($past(i_work) & $past(i_file_rd)) == 8'h00))
      else $error("zero flag wrong");
   // Literal AND: only the working register is written, with work AND literal.
   andk_work_a: assert property (chk_and_lit |=>
      o_work_we && !o_file_we &&
      o_work_wd == ($past(i_work) & $past(i_insn[`ABX_DATA_W-1:0])))
      else $error("literal and wrong");
   // Literal AND: the zero flag is written and tracks the literal result.
   andk_zero_a: assert property (chk_and_lit |=>
      o_zero_we && o_zero_val == (($past(i_work) & $past(i_insn[`ABX_DATA_W-1:0])) == 8'h00))
      else $error("literal zero flag wrong");
   // Bit clear: the selected bit goes low and no flag is touched.
   bclr_bit_a: assert property (chk_bit_clr |=>
      o_file_we && !o_zero_we && !o_file_wd[$past(i_insn[`ABX_BIT_HI:`ABX_BIT_LO])])
      else $error("bit clear wrong");
   // Bit clear: every other bit keeps the value that was read.
   bclr_keep_a: assert property (chk_bit_clr |=>
      (o_file_wd | (8'h01 << $past(i_insn[`ABX_BIT_HI:`ABX_BIT_LO]))) ==
      ($past(i_file_rd) | (8'h01 << $past(i_insn[`ABX_BIT_HI:`ABX_BIT_LO])))) else $error("clear disturbed others");
   // Bit set: the selected bit goes high and no flag is touched.
   bset_bit_a: assert property (chk_bit_set |=>
      o_file_we && !o_zero_we && o_file_wd[$past(i_insn[`ABX_BIT_HI:`ABX_BIT_LO])])
      else $error("bit set wrong");
   // Bit set: every other bit keeps the value that was read.
   bset_keep_a: assert property (chk_bit_set |=>
      (o_file_wd | (8'h01 << $past(i_insn[`ABX_BIT_HI:`ABX_BIT_LO]))) ==
      ($past(i_file_rd) | (8'h01 << $past(i_insn[`ABX_BIT_HI:`ABX_BIT_LO])))) else $error("set disturbed others");
   // A file write goes to the register named by the word before.
   file_addr_a: assert property (o_file_we |->
      o_file_waddr == $past(i_insn[`ABX_ADDR_W-1:0])) else $error("file address wrong");
   // An empty slot gives no write-back in the next cycle.
   one_cycle_a: assert property (!i_insn_vld |=> !o_work_we && !o_file_we && !o_zero_we)
      else $error("write without instruction");
   // The two destinations are never written together.
   no_double_a: assert property (o_work_we |-> !o_file_we) else $error("both destinations");

   //----------------------------------------------------------------------
   // Covers
   //----------------------------------------------------------------------
   // Register AND back to the file with a zero result.
   andf_zero_c: cover property (chk_and_file && i_insn[`ABX_DEST_BIT] ##1 o_zero_val);
   // Register AND into the working register.
   andf_work_c: cover property (chk_and_file && !i_insn[`ABX_DEST_BIT] ##1 o_work_we);
   // Literal AND into the working register.
   andk_c: cover property (chk_and_lit ##1 o_work_we);
   // Bit set lands in the file register.
   bset_c: cover property (chk_bit_set ##1 o_file_we);
   // Bit clear and bit set on consecutive cycles.
   bclr_bset_c: cover property (chk_bit_clr ##1 chk_bit_set);
endmodule : abx_exec

// *** core/abx_consts.svh ***
// Opcode patterns, field positions and widths for the logic-and bit-set/clear execute block.
`ifndef ABX_CONSTS_SVH
`define ABX_CONSTS_SVH
`define ABX_INSN_W 12
`define ABX_DATA_W 8
`define ABX_ADDR_W 5
`define ABX_OP6_HI 11
`define ABX_OP6_LO 6
`define ABX_OP4_HI 11
`define ABX_OP4_LO 8
`define ABX_OP_AND_FILE 6'h05
`define ABX_OP_AND_LIT 4'he
`define ABX_OP_BCLR 4'h4
`define ABX_OP_BSET 4'h5
`define ABX_DEST_BIT 5
`define ABX_BIT_HI 7
`define ABX_BIT_LO 5
`define ABX_RESULT_RST 8'h00
`endif

// *** core/abx_pkg.sv ***
// Types shared by the logic-and bit-set/clear execute block.
package abx_pkg;
   // Decoded operation of the current word.
   typedef enum logic [2:0]
   {
      ABX_OP_NONE = 3'h0,
      ABX_OP_ANDF = 3'h1,
      ABX_OP_ANDK = 3'h3,
      ABX_OP_BCLR = 3'h2,
      ABX_OP_BSET = 3'h6
   } abx_op_type;
   // Write-back request bundle.
   typedef struct packed
   {
      logic w_we;
      logic f_we;
      logic z_we;
      logic z_val;
      logic [4:0] f_addr;
      logic [7:0] data;
   } abx_wb_type;
endpackage : abx_pkg

// *** tb/abx_exec_bench.sv ***
// Self-checking bench for the logic-and bit-set/clear execute block.
`timescale 1ns/1ps
module abx_exec_bench;
   // Stimulus driven by the bench.
   logic i_clk = 1'b0;
   logic i_rst_n = 1'b0;
   logic i_insn_vld = 1'b0;
   logic [11:0] i_insn = 12'h000;
   logic [7:0] i_work = 8'h00;
   logic [7:0] i_file_rd = 8'h00;
   // Outputs watched by the bench.
   logic [4:0] o_file_raddr;
   logic [4:0] o_file_waddr;
   logic o_work_we, o_file_we, o_zero_we, o_zero_val;
   logic [7:0] o_work_wd, o_file_wd;
   // Counters of the run.
   int n_errors = 0;
   int comparisons = 0;
   int cycles = 0;
   abx_exec abx_exec_i (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_insn_vld(i_insn_vld),
      .i_insn(i_insn), .i_work(i_work), .i_file_rd(i_file_rd), .o_file_raddr(o_file_raddr),
      .o_work_we(o_work_we), .o_work_wd(o_work_wd), .o_file_we(o_file_we),
      .o_file_waddr(o_file_waddr), .o_file_wd(o_file_wd), .o_zero_we(o_zero_we),
      .o_zero_val(o_zero_val));
   // The clock toggles every half period of 5 ns.
   always #5 i_clk = ~i_clk;
   // A hang is cut short after a fixed number of cycles.
   always @(posedge i_clk)
   begin
      cycles <= cycles + 1;
      if (cycles == 2000)
      begin
         n_errors = n_errors + 1;
         finish_test();
      end
   end
   // Compares one value and reports a mismatch.
   task automatic chk(input logic [16:0] seen, input logic [16:0] exp);
      comparisons = comparisons + 1;
      if (seen !== exp)
      begin
         n_errors = n_errors + 1;
         $display("[FAIL] %0t ns: seen %h expected %h", $time, seen, exp);
      end
   endtask : chk
   // Presents one word for a cycle, judges the write-back and that it lasts one cycle.
   task automatic run(input logic [11:0] insn, input logic [7:0] w, input logic [7:0] f,
      input logic [3:0] en, input logic [7:0] d);
      @(posedge i_clk);
      i_insn_vld <= 1'b1;
      i_insn <= insn;
      i_work <= w;
      i_file_rd <= f;
      #1;
      chk({12'h000, o_file_raddr}, {12'h000, insn[4:0]});
      @(posedge i_clk);
      i_insn_vld <= 1'b0;
      #1;
      chk({o_work_we, o_file_we, o_zero_we, o_zero_we & o_zero_val,
         o_file_we ? o_file_waddr : 5'h00, o_work_we ? o_work_wd : (o_file_we ? o_file_wd : 8'h00)},
         {en, en[2] ? insn[4:0] : 5'h00, (en[3] | en[2]) ? d : 8'h00});
      @(posedge i_clk);
      #1;
      chk({14'h0000, o_work_we, o_file_we, o_zero_we}, 17'h00000);
   endtask : run
   // Register AND to work, then to file with a zero result.
   task automatic t_andf();
      run(12'h143, 8'h17, 8'hc2, 4'b1010, 8'h02);
      run(12'h17f, 8'h0f, 8'hf0, 4'b0111, 8'h00);
      $display("register and done");
   endtask : t_andf
   // Literal AND with a nonzero and a zero result.
   task automatic t_andk();
      run(12'he5f, 8'ha3, 8'hff, 4'b1010, 8'h03);
      run(12'he00, 8'hff, 8'h5a, 4'b1011, 8'h00);
      $display("literal and done");
   endtask : t_andk
   // Bit clear at both ends of the bit field and bit set at its top end, one at a time.
   task automatic t_bits();
      run(12'h4e3, 8'h00, 8'hc7, 4'b0100, 8'h47);
      run(12'h401, 8'h00, 8'hff, 4'b0100, 8'hfe);
      run(12'h5ea, 8'h00, 8'h0a, 4'b0100, 8'h8a);
      run(12'h41f, 8'h00, 8'h00, 4'b0100, 8'h00);
      $display("bit clear and set done");
   endtask : t_bits
   // Bit clear then bit set on consecutive cycles; each result stands one cycle.
   task automatic t_burst();
      @(posedge i_clk);
      i_insn_vld <= 1'b1;
      i_insn <= 12'h4e3;
      i_file_rd <= 8'hff;
      @(posedge i_clk);
      i_insn <= 12'h51f;
      i_file_rd <= 8'h00;
      #1;
      chk({o_file_we, o_zero_we, o_file_waddr, 2'b00, o_file_wd}, {2'b10, 5'h03, 2'b00, 8'h7f});
      @(posedge i_clk);
      i_insn_vld <= 1'b0;
      #1;
      chk({o_file_we, o_zero_we, o_file_waddr, 2'b00, o_file_wd}, {2'b10, 5'h1f, 2'b00, 8'h01});
      @(posedge i_clk);
      #1;
      chk({14'h0000, o_work_we, o_file_we, o_zero_we}, 17'h00000);
      $display("back to back done");
   endtask : t_burst
   // Neighbouring opcodes must give no write-back.
   task automatic t_refuse();
      run(12'h183, 8'hff, 8'hff, 4'b0000, 8'h00);
      run(12'h6e3, 8'hff, 8'hff, 4'b0000, 8'h00);
      $display("refused words done");
   endtask : t_refuse
   // Prints the counts and the verdict, then ends the run.
   task automatic finish_test();
      $display("comparisons %0d mismatches %0d", comparisons, n_errors);
      if (n_errors == 0 && comparisons > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask : finish_test
   // Main sequence: reset for 16 cycles, then every scenario in turn.
   initial
   begin
      repeat (16) @(posedge i_clk);
      i_rst_n <= 1'b1;
      t_andf();
      t_andk();
      t_bits();
      t_burst();
      t_refuse();
      finish_test();
   end
endmodule : abx_exec_bench
